// ==== cpu_regfile_data_addressing_tb_top.sv ====
// Self-checking bench for the register file core and its address unit.
// Assumes the far-side model answers a strobe within the same cycle.
`timescale 1ns/100ps
module cpu_regfile_data_addressing_tb_top;
	import crf_pkg::*;
	logic CLK = 1'b0;
	logic SRST = 1'b1;
	logic [9:0] PROG_ADDR, EXEC_PC, RET_PC;
	logic [15:0] PROG_DATA, INSN_WORD, MEM_ADDR;
	logic INSN_VALID, BUSY, MEM_RD, MEM_WR, MEM_IO, CALL_PULSE, FLAG_Z, FLAG_C;
	logic [7:0] MEM_WDATA, MEM_RDATA;
	logic OP_VALID = 1'b0;
	logic [3:0] OP_KIND = 4'h0, OP_ALU = 4'h0;
	logic [4:0] DST_FIELD = 5'h00, SRC_REG_FIELD = 5'h00;
	logic [7:0] IMM_FIELD = 8'h00;
	logic [11:0] aux = 12'h000;
	logic [7:0] seed = 8'h54;
	bit held = 1'b0;
	bit keep = 1'b0;
	int num_errors = 0;
	int n_compared = 0;
	always #10 CLK = ~CLK;
	crf_core #(.PROG_WORDS(1024)) u_crf_core (.CLK(CLK), .SRST(SRST),
		.PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA), .INSN_WORD(INSN_WORD),
		.INSN_VALID(INSN_VALID), .EXEC_PC(EXEC_PC), .BUSY(BUSY),
		.OP_VALID(OP_VALID), .OP_KIND(OP_KIND), .OP_ALU(OP_ALU),
		.DST_FIELD(DST_FIELD), .SRC_REG_FIELD(SRC_REG_FIELD),
		.IMM_FIELD(IMM_FIELD), .BIT_FIELD(aux[2:0]), .IO_FIELD(aux[5:0]),
		.DISP_FIELD(aux[5:0]), .PTR_FIELD(aux[9:8]),
		.AMODE_FIELD(aux[11:10]), .REL_FIELD(aux), .MEM_ADDR(MEM_ADDR),
		.MEM_WDATA(MEM_WDATA), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
		.MEM_IO(MEM_IO), .MEM_RDATA(MEM_RDATA), .CALL_PULSE(CALL_PULSE),
		.RET_PC(RET_PC), .FLAG_Z(FLAG_Z), .FLAG_C(FLAG_C));
	crf_mem_model u_crf_mem_model (.CLK(CLK), .PROG_ADDR(PROG_ADDR),
		.PROG_DATA(PROG_DATA), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
		.MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_RDATA(MEM_RDATA));
	// Carry in bit 8, result in bits 7:0
	function automatic logic [8:0] alu_exp(input logic [3:0] c,
		input logic [7:0] a, b, input logic [2:0] n);
		case (c)
			A_ADD: return {1'b0, a} + {1'b0, b};
			A_SUB: return {a < b, 8'(a - b)};
			A_AND: return {1'b0, a & b};
			A_OR: return {1'b0, a | b};
			A_EOR: return {1'b0, a ^ b};
			A_MOV: return {1'b0, b};
			A_INC: return {1'b0, 8'(a + 8'h01)};
			A_DEC: return {1'b0, 8'(a - 8'h01)};
			A_COM: return {1'b1, ~a};
			A_NEG: return {a != 8'h00, 8'(8'h00 - a)};
			A_LSR: return {a[0], a >> 1};
			A_SWAP: return {1'b0, a[3:0], a[7:4]};
			A_BSET: return {1'b0, a | (8'h01 << n)};
			A_BCLR: return {1'b0, a & ~(8'h01 << n)};
			default: return {1'b0, a};
		endcase
	endfunction
	task automatic rnd(output logic [7:0] v);
		seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
		v = seed;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic settle;
		int n;
		n = 0;
		while ((BUSY !== 1'b0 || INSN_VALID !== 1'b1) && n < 8) begin
			@(negedge CLK);
			n++;
		end
	endtask
	task automatic ws;
		int n;
		n = 0;
		while (MEM_RD !== 1'b1 && MEM_WR !== 1'b1 && n < 4) begin
			@(negedge CLK);
			n++;
		end
	endtask
	// Held valid keeps ops back to back with no idle decode cycle
	task automatic op(input logic [3:0] k, a, input logic [4:0] d, s,
		input logic [7:0] i, input logic [11:0] x);
		if (!held)
			@(negedge CLK);
		settle;
		OP_KIND = k;
		OP_ALU = a;
		DST_FIELD = d;
		SRC_REG_FIELD = s;
		IMM_FIELD = i;
		aux = x;
		OP_VALID = 1'b1;
		@(posedge CLK);
		@(negedge CLK);
		held = keep;
		if (!keep)
			OP_VALID = 1'b0;
	endtask
	task automatic getr(input logic [4:0] r, output logic [7:0] v);
		op(K_OUT, 4'h0, r, 5'h00, 8'h00, 12'h000);
		ws;
		chk(MEM_ADDR, 16'h0020);
		chk(MEM_IO, 1'b1);
		v = MEM_WDATA;
	endtask
	task automatic setr(input logic [4:0] r, input logic [7:0] v);
		if (r >= REG_UPPER_BASE) begin
			op(K_LDI, 4'h0, r, 5'h00, v, 12'h000);
		end else begin
			op(K_LDI, 4'h0, 5'h10, 5'h00, v, 12'h000);
			op(K_ALU_RR, A_MOV, r, 5'h10, 8'h00, 12'h000);
		end
	endtask
	task automatic sp(input logic [1:0] p, input logic [15:0] v);
		setr(PTR_X_LO + {2'b00, p, 1'b0}, v[7:0]);
		setr(PTR_X_HI + {2'b00, p, 1'b0}, v[15:8]);
	endtask
	task automatic chkp(input logic [1:0] p, input logic [15:0] e);
		logic [7:0] lo, hi;
		getr(PTR_X_LO + {2'b00, p, 1'b0}, lo);
		getr(PTR_X_HI + {2'b00, p, 1'b0}, hi);
		chk({hi, lo}, e);
	endtask
	task automatic acc(input logic [3:0] k, input logic [4:0] d,
		input logic [1:0] p, m, input logic [5:0] dsp, input logic [15:0] ea);
		op(k, 4'h0, d, 5'h00, 8'h00, {m, p, 2'b00, dsp});
		ws;
		if (ea >= DS_IO_BASE && ea < DS_END) begin
			chk(MEM_RD | MEM_WR, 1'b1);
			chk(MEM_ADDR, ea);
			chk(MEM_IO, ea < DS_SRAM_BASE);
			chk(BUSY, 1'b1);
		end else begin
			chk(MEM_RD | MEM_WR, 1'b0);
		end
	endtask
	initial begin
		#400000;
		num_errors++;
		end_sim;
	end
	initial begin
		logic [7:0] a, b, v;
		logic [7:0] ev [32];
		logic [9:0] pc, t;
		logic [11:0] k;
		logic [8:0] w;
		repeat (8) @(posedge CLK);
		@(negedge CLK);
		chk(PROG_ADDR, 10'h000);
		chk(INSN_VALID, 1'b0);
		chk(BUSY, 1'b0);
		SRST = 1'b0;
		for (int i = 0; i < 32; i++) begin
			rnd(ev[i]);
			setr(5'(i), ev[i]);
		end
		for (int i = 0; i < 32; i++) begin
			getr(5'(i), v);
			chk(v, ev[i]);
		end
		op(K_LDI, 4'h0, 5'h03, 5'h00, 8'h5a, 12'h000);
		op(K_ALU_RI, A_ADD, 5'h03, 5'h00, 8'h01, 12'h000);
		getr(5'h13, v);
		chk(v, 8'h5b);
		getr(5'h03, v);
		chk(v, ev[3]);
		for (int c = 0; c < 15; c++) begin
			rnd(a);
			rnd(b);
			setr(5'h14, a);
			setr(5'h15, b);
			w = alu_exp(4'(c), a, b, b[2:0]);
			op(c >= 6 ? K_ALU_R : K_ALU_RR, 4'(c), 5'h14, 5'h15, 8'h00,
				{9'h000, b[2:0]});
			chk(FLAG_Z, w[7:0] == 8'h00);
			chk(FLAG_C, w[8]);
			getr(5'h14, v);
			chk(v, w[7:0]);
		end
		rnd(a);
		rnd(b);
		setr(5'h12, a);
		u_crf_mem_model.dmem[8'h60] = b;
		sp(PTR_X, 16'h0060);
		acc(K_LD, 5'h11, PTR_X, 2'h2, 6'h00, 16'h0060);
		getr(5'h11, v);
		chk(v, b);
		chkp(PTR_X, 16'h0061);
		sp(PTR_X, 16'h00ff);
		acc(K_ST, 5'h12, PTR_X, 2'h2, 6'h00, 16'h00ff);
		chkp(PTR_X, 16'h0100);
		sp(PTR_Y, 16'h0100);
		acc(K_LD, 5'h13, PTR_Y, 2'h1, 6'h00, 16'h00ff);
		getr(5'h13, v);
		chk(v, UNMAPPED_READ);
		chkp(PTR_Y, 16'h00ff);
		sp(PTR_Z, 16'h0060);
		acc(K_LD, 5'h11, PTR_Z, 2'h3, 6'h3f, 16'h009f);
		getr(5'h11, v);
		chk(v, 8'(8'h9f * 8'h07 + 8'h03));
		chkp(PTR_Z, 16'h0060);
		sp(PTR_Y, 16'h005f);
		acc(K_ST, 5'h12, PTR_Y, 2'h0, 6'h00, 16'h005f);
		chk(MEM_WDATA, a);
		chkp(PTR_Y, 16'h005f);
		acc(K_LD, 5'h11, PTR_Y, 2'h3, 6'h01, 16'h0060);
		getr(5'h11, v);
		chk(v, b);
		sp(PTR_X, 16'h0005);
		acc(K_ST, 5'h12, PTR_X, 2'h0, 6'h00, 16'h0005);
		getr(5'h05, v);
		chk(v, a);
		op(K_IN, 4'h0, 5'h18, 5'h00, 8'h00, 12'h03f);
		ws;
		chk(MEM_ADDR, 16'h005f);
		chk(MEM_RD, 1'b1);
		getr(5'h18, v);
		chk(v, a);
		u_crf_mem_model.prog[10'h052] = {a, b};
		for (int h = 0; h < 2; h++) begin
			sp(PTR_Z, 16'h00a4 | 16'(h));
			op(K_LPM, 4'h0, 5'h16, 5'h00, 8'h00, 12'h000);
			chk(BUSY, 1'b1);
			getr(5'h16, v);
			chk(v, h ? a : b);
		end
		setr(5'h14, a);
		sp(PTR_Z, 16'h0123);
		keep = 1'b1;
		op(K_JUMP_VIA_POINTER, 4'h0, 5'h00, 5'h00, 8'h00, 12'h000);
		chk(PROG_ADDR, 10'h123);
		settle;
		chk(EXEC_PC, 10'h123);
		chk(INSN_WORD, u_crf_mem_model.prog[10'h123]);
		for (int i = 0; i < 4; i++) begin
			op(K_ALU_R, A_INC, 5'h14, 5'h00, 8'h00, 12'h000);
		end
		settle;
		chk(EXEC_PC, 10'h127);
		pc = 10'h127;
		for (int i = 0; i < 3; i++) begin
			k = i == 0 ? 12'h800 : (i == 1 ? 12'h7ff : {4'h0, b});
			t = pc + k[9:0] + 10'h001;
			op(i == 1 ? K_RJMP : K_CALL_RELATIVE, 4'h0, 5'h00, 5'h00, 8'h00, k);
			chk(CALL_PULSE, i != 1);
			if (i != 1)
				chk(RET_PC, pc + 10'h001);
			chk(PROG_ADDR, t);
			settle;
			pc = t;
		end
		op(K_CALL_VIA_POINTER, 4'h0, 5'h00, 5'h00, 8'h00, 12'h000);
		chk(CALL_PULSE, 1'b1);
		chk(RET_PC, 10'(pc + 10'h001));
		chk(PROG_ADDR, 10'h123);
		settle;
		pc = 10'h123;
		rnd(b);
		u_crf_mem_model.prog[pc + 10'h001] = 16'h00df;
		u_crf_mem_model.prog[pc + 10'h003] = 16'h0007;
		u_crf_mem_model.dmem[8'hdf] = b;
		op(K_LDS, 4'h0, 5'h15, 5'h00, 8'h00, 12'h000);
		ws;
		chk(MEM_ADDR, 16'h00df);
		keep = 1'b0;
		op(K_STS, 4'h0, 5'h14, 5'h00, 8'h00, 12'h000);
		getr(5'h15, v);
		chk(v, b);
		getr(5'h07, v);
		chk(v, 8'(a + 8'h04));
		end_sim;
	end
endmodule

// ==== crf_agu.sv ====
// Operand address unit: effective data address and stepped pointer.
// Purely combinational; the core writes the stepped pointer back.
`timescale 1ns/100ps
module crf_agu
	import crf_pkg::*;
(
	crf_agu_if.agu bus
);
	logic [15:0] base;
	logic use_disp;
	logic [15:0] io_addr;

	assign base = (bus.sel == PTR_Z) ? bus.z :
		(bus.sel == PTR_Y) ? bus.y : bus.x;
	// No displacement form exists for the first pointer
	assign use_disp = (bus.mode == AM_DISP) && (bus.sel != PTR_X);
	assign io_addr = DS_IO_BASE + {10'h000, bus.io};
	// Full 16-bit step so the carry reaches the high byte
	assign bus.ptr_new = (bus.mode == AM_PREDEC) ? base - 16'h0001 :
		base + 16'h0001;
	assign bus.ptr_wr = (bus.mode == AM_PREDEC) ||
		(bus.mode == AM_POSTINC);
	assign bus.eff = (bus.mode == AM_DIRECT) ? bus.direct :
		(bus.mode == AM_IO) ? io_addr :
		(bus.mode == AM_PREDEC) ? bus.ptr_new :
		use_disp ? base + {10'h000, bus.disp} :
		base;

	disp_offset_a: assert property (
		@(posedge bus.clk) disable iff (bus.rst)
		(bus.mode == AM_DISP && bus.sel == PTR_Y) |->
		bus.eff == bus.y + {10'h000, bus.disp} && !bus.ptr_wr)
		else $error("displacement address wrong");
	plain_hold_a: assert property (
		@(posedge bus.clk) disable iff (bus.rst)
		(bus.mode == AM_PLAIN) |-> bus.eff == base && !bus.ptr_wr)
		else $error("plain indirect moved pointer");
	pre_dec_a: assert property (
		@(posedge bus.clk) disable iff (bus.rst)
		(bus.mode == AM_PREDEC) |->
		bus.eff == base - 16'h0001 && bus.ptr_new == bus.eff)
		else $error("pre-decrement address wrong");
	post_inc_a: assert property (
		@(posedge bus.clk) disable iff (bus.rst)
		(bus.mode == AM_POSTINC) |->
		bus.eff == base && bus.ptr_new == base + 16'h0001)
		else $error("post-increment address wrong");
endmodule

// ==== crf_agu_if.sv ====
// Carrier between the core and its operand address unit.
// Core drives pointers and mode; the unit answers combinationally.
`timescale 1ns/100ps
interface crf_agu_if;
	import crf_pkg::*;
	logic clk;
	logic rst;
	logic [15:0] x;
	logic [15:0] y;
	logic [15:0] z;
	crf_ptr_t sel;
	crf_amode_t mode;
	logic [5:0] disp;
	logic [5:0] io;
	logic [15:0] direct;
	logic [15:0] eff;
	logic [15:0] ptr_new;
	logic ptr_wr;
	modport core (output clk, rst, x, y, z, sel, mode, disp, io, direct,
		input eff, ptr_new, ptr_wr);
	modport agu (input clk, rst, x, y, z, sel, mode, disp, io, direct,
		output eff, ptr_new, ptr_wr);
endinterface

// ==== crf_core.sv ====
// Register file, ALU, fetch sequencing and data-space access of the core.
// Assumes an asynchronous-read program memory and a decoder that decodes
// INSN_WORD in the same cycle; I/O and SRAM answer within the strobe cycle.
`timescale 1ns/100ps
module crf_core
	import crf_pkg::*;
#(
	parameter int unsigned PROG_WORDS = 1024
)(
	input logic CLK,
	input logic SRST,
	output logic [9:0] PROG_ADDR,
	input logic [15:0] PROG_DATA,
	output logic [15:0] INSN_WORD,
	output logic INSN_VALID,
	output logic [9:0] EXEC_PC,
	output logic BUSY,
	input logic OP_VALID,
	input logic [3:0] OP_KIND,
	input logic [3:0] OP_ALU,
	input logic [4:0] DST_FIELD,
	input logic [4:0] SRC_REG_FIELD,
	input logic [7:0] IMM_FIELD,
	input logic [2:0] BIT_FIELD,
	input logic [5:0] IO_FIELD,
	input logic [5:0] DISP_FIELD,
	input logic [1:0] PTR_FIELD,
	input logic [1:0] AMODE_FIELD,
	input logic [11:0] REL_FIELD,
	output logic [15:0] MEM_ADDR,
	output logic [7:0] MEM_WDATA,
	output logic MEM_RD,
	output logic MEM_WR,
	output logic MEM_IO,
	input logic [7:0] MEM_RDATA,
	output logic CALL_PULSE,
	output logic [9:0] RET_PC,
	output logic FLAG_Z,
	output logic FLAG_C
);
	if (PROG_WORDS != (1 << PC_W)) begin : g_bad_size
		$error("PROG_WORDS must match the counter width");
	end

	function automatic crf_region_t region_of(input logic [15:0] a);
		if (a < DS_IO_BASE) return REGION_REG;
		else if (a < DS_SRAM_BASE) return REGION_IO;
		else if (a < DS_END) return REGION_SRAM;
		else return REGION_NONE;
	endfunction

	logic [7:0] regs_q [REG_COUNT];
	crf_state_t state_q, state_d;
	logic [9:0] pc_q, pc_d;
	logic [9:0] prog_addr_q, prog_addr_d;
	logic [15:0] insn_q;
	logic insn_v_q;
	logic [9:0] exec_pc_q;
	crf_kind_t sv_kind_q;
	logic [4:0] sv_dst_q;
	logic [15:0] mem_addr_q;
	logic [7:0] mem_wdata_q;
	logic mem_rd_q, mem_wr_q, mem_io_q;
	logic call_q;
	logic [9:0] ret_pc_q;
	logic flag_z_q, flag_c_q;
	logic busy_q;

	crf_agu_if agu_bus ();
	crf_agu u_agu (
		.bus(agu_bus)
	);

	logic in_run, go;
	crf_kind_t kind;
	crf_alu_t alu_op;
	logic [4:0] dst;
	logic [4:0] dst_idx;
	logic [15:0] ptr_x, ptr_y, ptr_z;
	logic [7:0] rd_a, rd_b, alu_b, acc_rdata;
	logic is_ld, is_st, is_acc;
	crf_region_t region;
	logic acc_reg, acc_ext, acc_none;
	logic is_alu, is_jump, is_call, two_word, hold_run, adv;
	logic [9:0] rel_tgt, jmp_tgt;
	logic [7:0] lpm_byte;
	logic we_a, we_p;
	logic [4:0] wa;
	logic [7:0] wd;
	logic [4:0] pidx;
	logic [8:0] alu_res;

	// Pointer pairs, low byte in the even register
	assign ptr_x = {regs_q[PTR_X_HI], regs_q[PTR_X_LO]};
	assign ptr_y = {regs_q[PTR_Y_HI], regs_q[PTR_Y_LO]};
	assign ptr_z = {regs_q[PTR_Z_HI], regs_q[PTR_Z_LO]};

	assign in_run = (state_q == S_RUN);
	assign go = in_run && insn_v_q && OP_VALID;
	// Second word of a direct access: the decoder output is stale then
	assign kind = (state_q == S_WORD2) ? sv_kind_q :
		go ? crf_kind_t'(OP_KIND) : K_NOP;
	assign alu_op = crf_alu_t'(OP_ALU);
	assign dst = in_run ? DST_FIELD : sv_dst_q;
	assign dst_idx = (kind == K_ALU_RI || kind == K_LDI) ?
		(REG_UPPER_BASE | {1'b0, dst[3:0]}) : dst;
	assign rd_a = regs_q[dst_idx];
	assign rd_b = regs_q[SRC_REG_FIELD];
	assign alu_b = (kind == K_ALU_RI) ? IMM_FIELD : rd_b;

	assign agu_bus.clk = CLK;
	assign agu_bus.rst = SRST;
	assign agu_bus.x = ptr_x;
	assign agu_bus.y = ptr_y;
	assign agu_bus.z = ptr_z;
	assign agu_bus.sel = crf_ptr_t'(PTR_FIELD);
	assign agu_bus.disp = DISP_FIELD;
	assign agu_bus.io = IO_FIELD;
	assign agu_bus.direct = insn_q;
	assign agu_bus.mode = (state_q == S_WORD2) ? AM_DIRECT :
		(kind == K_IN || kind == K_OUT) ? AM_IO :
		crf_amode_t'({1'b0, AMODE_FIELD});

	assign is_ld = (kind == K_IN) || (kind == K_LD) ||
		(state_q == S_WORD2 && kind == K_LDS);
	assign is_st = (kind == K_OUT) || (kind == K_ST) ||
		(state_q == S_WORD2 && kind == K_STS);
	assign is_acc = is_ld || is_st;
	assign region = region_of(agu_bus.eff);
	assign acc_reg = is_acc && (region == REGION_REG);
	assign acc_ext = is_acc && (region == REGION_IO ||
		region == REGION_SRAM);
	assign acc_none = is_acc && (region == REGION_NONE);
	assign acc_rdata = regs_q[agu_bus.eff[4:0]];

	assign is_alu = (kind == K_ALU_RR) || (kind == K_ALU_RI) ||
		(kind == K_ALU_R);
	assign is_call = (kind == K_CALL_VIA_POINTER) || (kind == K_CALL_RELATIVE);
	assign is_jump = is_call || (kind == K_JUMP_VIA_POINTER) || (kind == K_RJMP);
	assign two_word = in_run && (kind == K_LDS || kind == K_STS);
	// Offset is taken modulo the 1K space, so only its low bits matter
	assign rel_tgt = exec_pc_q + REL_FIELD[9:0] + 10'h001;
	assign jmp_tgt = (kind == K_JUMP_VIA_POINTER || kind == K_CALL_VIA_POINTER) ?
		ptr_z[9:0] : rel_tgt;
	assign lpm_byte = ptr_z[0] ? PROG_DATA[15:8] :
		PROG_DATA[7:0];

	// Stall only for external accesses and constant fetch
	assign hold_run = go && (acc_ext || kind == K_LPM);
	assign adv = (in_run && !hold_run && !is_jump) ||
		(state_q == S_WORD2 && !acc_ext) ||
		(state_q == S_MEM);
	assign pc_d = is_jump ? jmp_tgt :
		adv ? pc_q + 10'h001 : pc_q;
	assign prog_addr_d = (go && kind == K_LPM) ? ptr_z[10:1] :
		pc_d;

	always_comb begin
		alu_res = {1'b0, rd_a};
		unique case (alu_op)
			A_ADD: alu_res = {1'b0, rd_a} + {1'b0, alu_b};
			A_SUB: alu_res = {1'b0, rd_a} - {1'b0, alu_b};
			A_AND: alu_res = {1'b0, rd_a & alu_b};
			A_OR: alu_res = {1'b0, rd_a | alu_b};
			A_EOR: alu_res = {1'b0, rd_a ^ alu_b};
			A_MOV: alu_res = {1'b0, alu_b};
			A_INC: alu_res = {1'b0, rd_a + 8'h01};
			A_DEC: alu_res = {1'b0, rd_a - 8'h01};
			A_COM: alu_res = {1'b1, ~rd_a};
			A_NEG: alu_res = 9'h000 - {1'b0, rd_a};
			A_LSR: alu_res = {rd_a[0], 1'b0, rd_a[7:1]};
			A_SWAP: alu_res = {1'b0, rd_a[3:0], rd_a[7:4]};
			A_BSET: alu_res = {1'b0, rd_a | (8'h01 << BIT_FIELD)};
			A_BCLR: alu_res = {1'b0, rd_a & ~(8'h01 << BIT_FIELD)};
			default: alu_res = {1'b0, rd_a};
		endcase
	end

	// Write-back selection; the byte port lands after the pointer port
	assign we_a = is_alu || kind == K_LDI || (is_ld && !acc_ext) ||
		(is_st && acc_reg) || (state_q == S_MEM && mem_rd_q) ||
		(state_q == S_LPM);
	assign wa = (state_q == S_MEM || state_q == S_LPM) ? sv_dst_q :
		(is_st && acc_reg) ? agu_bus.eff[4:0] : dst_idx;
	assign wd = (state_q == S_MEM) ? MEM_RDATA :
		(state_q == S_LPM) ? lpm_byte :
		is_alu ? alu_res[7:0] :
		(kind == K_LDI) ? IMM_FIELD :
		acc_none ? UNMAPPED_READ :
		is_ld ? acc_rdata : rd_a;
	assign we_p = (kind == K_LD || kind == K_ST) &&
		agu_bus.ptr_wr;
	assign pidx = (agu_bus.sel == PTR_Z) ? PTR_Z_LO :
		(agu_bus.sel == PTR_Y) ? PTR_Y_LO : PTR_X_LO;

	always_ff @(posedge CLK) begin
		if (SRST) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs_q[i] <= REG_RESET;
			end
		end else begin
			if (we_p) begin
				regs_q[pidx] <= agu_bus.ptr_new[7:0];
				regs_q[{pidx[4:1], 1'b1}] <= agu_bus.ptr_new[15:8];
			end
			if (we_a) begin
				regs_q[wa] <= wd;
			end
		end
	end

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			S_RUN: begin
				if (two_word) state_d = S_WORD2;
				else if (go && acc_ext) state_d = S_MEM;
				else if (go && kind == K_LPM) state_d = S_LPM;
			end
			S_WORD2: state_d = acc_ext ? S_MEM : S_RUN;
			S_MEM: state_d = S_RUN;
			S_LPM: state_d = S_RUN;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_q <= S_RUN;
			pc_q <= PC_RESET;
			prog_addr_q <= PC_RESET;
			sv_kind_q <= K_NOP;
			sv_dst_q <= 5'h00;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			// Registered copy of the state test keeps the pin glitch free
			busy_q <= (state_d != S_RUN);
			pc_q <= pc_d;
			prog_addr_q <= prog_addr_d;
			if (in_run) begin
				sv_kind_q <= kind;
				sv_dst_q <= dst;
			end
		end
	end

	// Fetch register; a jump or constant fetch leaves one bubble
	always_ff @(posedge CLK) begin
		if (SRST) begin
			insn_q <= 16'h0000;
			insn_v_q <= 1'b0;
			exec_pc_q <= PC_RESET;
		end else if (adv) begin
			insn_q <= PROG_DATA;
			insn_v_q <= 1'b1;
			exec_pc_q <= pc_q;
		end else if (is_jump || state_q == S_LPM) begin
			insn_v_q <= 1'b0;
		end
	end

	// Strobes stand for the second half of the two-cycle access
	always_ff @(posedge CLK) begin
		if (SRST) begin
			mem_addr_q <= 16'h0000;
			mem_wdata_q <= 8'h00;
			mem_rd_q <= 1'b0;
			mem_wr_q <= 1'b0;
			mem_io_q <= 1'b0;
		end else begin
			mem_rd_q <= acc_ext && is_ld;
			mem_wr_q <= acc_ext && is_st;
			if (acc_ext) begin
				mem_addr_q <= agu_bus.eff;
				mem_wdata_q <= rd_a;
				mem_io_q <= (region == REGION_IO);
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			call_q <= 1'b0;
			ret_pc_q <= PC_RESET;
			flag_z_q <= 1'b0;
			flag_c_q <= 1'b0;
		end else begin
			call_q <= is_call;
			if (is_call) ret_pc_q <= pc_q;
			if (is_alu) begin
				flag_z_q <= (alu_res[7:0] == 8'h00);
				flag_c_q <= alu_res[8];
			end
		end
	end

	assign PROG_ADDR = prog_addr_q;
	assign INSN_WORD = insn_q;
	assign INSN_VALID = insn_v_q;
	assign EXEC_PC = exec_pc_q;
	assign BUSY = busy_q;
	assign MEM_ADDR = mem_addr_q;
	assign MEM_WDATA = mem_wdata_q;
	assign MEM_RD = mem_rd_q;
	assign MEM_WR = mem_wr_q;
	assign MEM_IO = mem_io_q;
	assign CALL_PULSE = call_q;
	assign RET_PC = ret_pc_q;
	assign FLAG_Z = flag_z_q;
	assign FLAG_C = flag_c_q;

	imm_upper_a: assert property (@(posedge CLK) disable iff (SRST)
		(go && (kind == K_ALU_RI || kind == K_LDI)) |-> wa[4] && we_a)
		else $error("immediate op hit lower register");
	sram_two_a: assert property (@(posedge CLK) disable iff (SRST)
		(in_run && go && acc_ext) |=> (MEM_RD || MEM_WR) && BUSY
		##1 !(MEM_RD || MEM_WR) && !BUSY)
		else $error("external access not two cycles");
	rel_jump_a: assert property (@(posedge CLK) disable iff (SRST)
		(go && kind == K_RJMP) |=> PROG_ADDR ==
		10'($past(exec_pc_q) + $past(REL_FIELD[9:0]) + 10'h001))
		else $error("relative target wrong");
	ind_jump_a: assert property (@(posedge CLK) disable iff (SRST)
		(go && kind == K_JUMP_VIA_POINTER) |=>
		PROG_ADDR == $past(ptr_z[9:0]) && !INSN_VALID)
		else $error("indirect jump target wrong");
	reg_window_a: assert property (@(posedge CLK) disable iff (SRST)
		acc_reg |=> !MEM_RD && !MEM_WR)
		else $error("register address went external");
	io_map_a: assert property (@(posedge CLK) disable iff (SRST)
		(go && kind == K_IN) |=> MEM_RD && MEM_IO &&
		MEM_ADDR == DS_IO_BASE + {10'h000, $past(IO_FIELD)})
		else $error("I/O address not offset by 32");
	single_cyc_a: assert property (@(posedge CLK) disable iff (SRST)
		(go && kind == K_ALU_RR) |=>
		PROG_ADDR == 10'($past(PROG_ADDR) + 10'h001) && INSN_VALID)
		else $error("register op stalled fetch");
	lpm_fetch_a: assert property (@(posedge CLK) disable iff (SRST)
		(go && kind == K_LPM) |=> PROG_ADDR == $past(ptr_z[10:1])
		##1 !INSN_VALID && !BUSY)
		else $error("constant fetch word address wrong");
endmodule

// ==== crf_mem_model.sv ====
// Far-side model: program memory, I/O registers and data SRAM.
// Assumes core strobes last one cycle; read data is taken in that cycle.
`timescale 1ns/100ps
module crf_mem_model (
	input logic CLK,
	input logic [9:0] PROG_ADDR,
	output logic [15:0] PROG_DATA,
	input logic [15:0] MEM_ADDR,
	input logic [7:0] MEM_WDATA,
	input logic MEM_RD,
	input logic MEM_WR,
	output logic [7:0] MEM_RDATA
);
	logic [15:0] prog [0:1023];
	logic [7:0] dmem [0:255];
	logic [7:0] last_q;
	initial begin
		last_q = 8'h00;
		for (int i = 0; i < 1024; i++) begin
			prog[i] = 16'(i * 16'h9e37 + 16'h1234);
		end
		for (int i = 0; i < 256; i++) begin
			dmem[i] = 8'(i * 8'h07 + 8'h03);
		end
	end
	// Combinational word read, one word per address
	assign PROG_DATA = prog[PROG_ADDR];
	// Valid only while strobed; otherwise a toggling wrong value
	assign MEM_RDATA = MEM_RD ? dmem[MEM_ADDR[7:0]] : ~last_q;
	always @(posedge CLK) begin
		last_q <= MEM_RDATA;
		if (MEM_WR) begin
			dmem[MEM_ADDR[7:0]] <= MEM_WDATA;
		end
	end
endmodule

// ==== crf_pkg.sv ====
// Constants and types shared by the register file core and its address unit.
// Assumes one 50 MHz clock and a synchronous active-high reset.
// Summary of operation
// - Thirty-two byte registers, also seen at data addresses 0 to 31.
// - Immediate and load-immediate operations reach only registers 16 to 31.
// - Two-register and one-register operations reach any register, one cycle.
// - Registers 26 to 31 form three 16-bit pointers, low byte first.
// - Decoder covers 224 addresses: 96 registers plus I/O, then 128 SRAM.
// - I/O location n also sits at data address n plus 32.
// - I/O direct takes a 6-bit address field and a register field.
// - Direct mode takes a 16-bit address from the second word.
// - Displacement mode adds an unsigned 6-bit offset to second or third pointer.
// - Plain indirect uses the pointer as is and leaves it unchanged.
// - Pre-decrement lowers the pointer first and uses the lowered value.
// - Post-increment uses the old pointer, then raises it.
// - Constant fetch: third pointer upper bits pick word, bit 0 picks byte.
// - Indirect jump and call load the program counter from the third pointer.
// - Relative jump and call go to counter plus signed offset plus one.
// - Program counter is 10 bits over 1024 sixteen-bit words.
// - Two operands read and result written back in the same cycle.
// - ALU offers arithmetic, logic and bit functions on register operands.
// - An SRAM access takes two clock cycles.
// - Core steps on every clock edge, with no division.
// - Next instruction is fetched while the current one executes.
package crf_pkg;
	localparam int unsigned REG_COUNT = 32;
	localparam logic [4:0] REG_UPPER_BASE = 5'h10;
	localparam logic [4:0] PTR_X_LO = 5'h1a;
	localparam logic [4:0] PTR_X_HI = 5'h1b;
	localparam logic [4:0] PTR_Y_LO = 5'h1c;
	localparam logic [4:0] PTR_Y_HI = 5'h1d;
	localparam logic [4:0] PTR_Z_LO = 5'h1e;
	localparam logic [4:0] PTR_Z_HI = 5'h1f;
	localparam logic [15:0] DS_IO_BASE = 16'h0020;
	localparam logic [15:0] DS_SRAM_BASE = 16'h0060;
	localparam logic [15:0] DS_END = 16'h00e0;
	localparam int unsigned PC_W = 10;
	localparam logic [9:0] PC_RESET = 10'h000;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	typedef enum logic [3:0] {K_NOP, K_ALU_RR, K_ALU_RI, K_ALU_R, K_LDI,
		K_IN, K_OUT, K_LD, K_ST, K_LDS, K_STS, K_LPM, K_JUMP_VIA_POINTER, K_CALL_VIA_POINTER,
		K_RJMP, K_CALL_RELATIVE} crf_kind_t;
	typedef enum logic [3:0] {A_ADD, A_SUB, A_AND, A_OR, A_EOR, A_MOV,
		A_INC, A_DEC, A_COM, A_NEG, A_LSR, A_SWAP, A_BSET,
		A_BCLR} crf_alu_t;
	typedef enum logic [2:0] {AM_PLAIN, AM_PREDEC, AM_POSTINC, AM_DISP,
		AM_DIRECT, AM_IO} crf_amode_t;
	typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} crf_ptr_t;
	typedef enum logic [1:0] {REGION_REG, REGION_IO, REGION_SRAM,
		REGION_NONE} crf_region_t;
	typedef enum logic [1:0] {S_RUN, S_WORD2, S_MEM, S_LPM} crf_state_t;
endpackage
